// *** core/prs_pkg.sv ***
// Package: register map, field positions and timing for the scaler
package prs_pkg;
    localparam int POS_W = 18;
    localparam int RES_W = 19;
    localparam int PROD_W = POS_W + RES_W;

    localparam logic [7:0] ADDR_OUTPUT_MODE = 8'h07;
    localparam logic [7:0] ADDR_SCALER_CTRL = 8'h0b;
    localparam logic [7:0] ADDR_OFFSET_LOW = 8'h0c;
    localparam logic [7:0] ADDR_OFFSET_MID = 8'h0d;
    localparam logic [7:0] ADDR_INTERP_HIGH = 8'h0e;
    localparam logic [7:0] ADDR_SCALE_LOW = 8'h0f;
    localparam logic [7:0] ADDR_SCALE_MID = 8'h10;
    localparam logic [7:0] ADDR_SCALE_HIGH = 8'h11;
    localparam logic [7:0] ADDR_POS_STATUS = 8'h12;

    localparam int BIT_MODE_SEL = 4;
    localparam int BIT_DIR = 5;
    localparam int BIT_SCALER_DISABLE = 1;
    localparam int BIT_ABS_RES_SEL = 2;
    localparam int BIT_ABZ_TRISTATE = 3;
    localparam int BIT_HALT = 5;
    localparam int BIT_FORCE_LOW_N = 6;
    localparam int BIT_POS_VALID = 0;

    localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] RST_SCALER_CTRL = 8'h08;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_SCALE_LOW = 8'h7f;
    localparam logic [7:0] RST_SCALE_MID = 8'h7f;
    localparam logic [7:0] RST_SCALE_HIGH = 8'h0f;

    localparam logic [17:0] SCALE_MIN = 18'h00003;
    localparam logic [17:0] SCALE_MAX = 18'h3ffff;

    localparam int CLK_PERIOD_NS = 50;
    localparam int POWER_OK_DELAY_NS = 10000;
    localparam int POWER_OK_CYCLES =
        (POWER_OK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWR_CNT_W = 8;
endpackage : prs_pkg

// *** core/prs_gray_map.sv ***
// Centred Gray mapping of a scaled count and its excess
`timescale 1ns/1ns
`default_nettype none
module prs_gray_map (
    input  wire logic [17:0] scale,
    input  wire logic [17:0] count,
    output logic      [17:0] excess,
    output logic      [17:0] gray
);
    logic [18:0] full_span;
    logic [18:0] res;
    logic [17:0] shifted;
    int          msb;

    always_comb begin
        msb = 0;
        for (int i = 0; i < 18; i++) begin
            if (scale[i]) begin
                msb = i;
            end
        end
        // N = index of top set bit + 1; power-of-two sizes give zero excess
        full_span = 19'h00001 << (msb + 1);
        res = {1'b0, scale} + 19'h00001;
        excess = 18'((full_span - res) >> 1);
        shifted = count + excess;
        gray = shifted ^ (shifted >> 1);
    end
endmodule : prs_gray_map
`default_nettype wire

// *** core/prs_scaler.sv ***
// Programmable resolution scaler with register file and outputs
//
// Summary of operation
// - Scale register holds wanted counts per revolution minus one, 4 to 262144.
// - Scale bits 17:14, 13:7, 6:0 come from registers 0x11, 0x10, 0x0f.
// - Power-of-two resolutions output Gray from zero to scale, one-bit steps.
// - Power-of-two: Gray zero at disc zero, MSB falling edge, normal direction.
// - Other resolutions use central span of n-bit Gray code, wrap included.
// - Excess equals two to the N minus resolution, halved.
// - Other resolutions output the excess at disc zero.
// - Scaler runs while halt bit is 0, stops while it is 1.
// - Clearing halt restarts scaler from zero, which counts the short way round to current position.
// - With scaled absolute, position-valid reads 0 during catch-up, 1 once outputs valid.
// - Output-normal 0 with tristate off forces quadrature and index low.
// - Mode bit 0 selects interface mode, 1 selects parallel mode.
// - Interface mode gives absolute word and quadrature A and B.
// - Interface mode with scaler enabled: programmable resolution plus index.
// - Two Gray outputs carry top two bits of full absolute position.
// - A power-ok output signals the device is ready.
// - Disable bit 0 enables the scaler, 1 bypasses it.
// - Absolute-select 0 uses scaled resolution, 1 maximum resolution.
// - Effective direction is pin XOR register bit.
// - Offset bits 17:14, 13:7, 6:0 come from registers 0x0e, 0x0d, 0x0c.
`timescale 1ns/1ns
`default_nettype none
module prs_scaler (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    output logic      [7:0]  reg_rdata,
    input  wire logic [17:0] abs_position,
    input  wire logic        abs_position_ok,
    input  wire logic        dir_pin,
    output logic             quad_a_out,
    output logic             quad_b_out,
    output logic             index_out,
    output logic             abz_oe,
    output logic             gray_msb_out,
    output logic             gray_msb1_out,
    output logic             power_ok_out,
    output logic             parallel_mode,
    output logic      [17:0] abs_word_out,
    output logic             position_valid
);
    localparam int PROD_W_L = prs_pkg::PROD_W;
    localparam int PWR_W_L = prs_pkg::PWR_CNT_W;
    // Settling count sized to the counter so the compare is exact
    localparam logic [PWR_W_L-1:0] PWR_DONE =
        PWR_W_L'(prs_pkg::POWER_OK_CYCLES);

    logic [7:0]  output_mode_config;
    logic [7:0]  scaler_ctrl;
    logic [7:0]  offset_low_bits;
    logic [7:0]  offset_mid_bits;
    logic [7:0]  interp_and_offset_high;
    logic [7:0]  scale_low_bits;
    logic [7:0]  scale_mid_bits;
    logic [7:0]  scale_high_and_control;
    logic [17:0] scale_count_minus_one;
    logic [17:0] position_offset;
    logic        scaler_halt;
    logic        abz_force_low_n;
    logic        abz_tristate;
    logic        scaler_disable;
    logic        absolute_res_sel;
    logic        output_mode_sel;
    logic        count_dir;
    logic        halt_q;
    logic [17:0] rel_pos;
    logic [PROD_W_L-1:0] product;
    logic [17:0] target;
    logic [17:0] count;
    logic [17:0] next_count;
    logic [18:0] diff;
    logic [18:0] res;
    logic [17:0] excess;
    logic [17:0] scaled_gray;
    logic [17:0] full_gray;
    logic [prs_pkg::PWR_CNT_W-1:0] pwr_cnt;
    logic        quad_a;
    logic        quad_b;
    logic        index;

    always_comb begin
        scale_count_minus_one = {scale_high_and_control[3:0],
                                 scale_mid_bits[6:0],
                                 scale_low_bits[6:0]};
        position_offset = {interp_and_offset_high[3:0],
                           offset_mid_bits[6:0],
                           offset_low_bits[6:0]};
        scaler_halt = scale_high_and_control[prs_pkg::BIT_HALT];
        abz_force_low_n = scale_high_and_control[prs_pkg::BIT_FORCE_LOW_N];
        abz_tristate = scaler_ctrl[prs_pkg::BIT_ABZ_TRISTATE];
        scaler_disable = scaler_ctrl[prs_pkg::BIT_SCALER_DISABLE];
        absolute_res_sel = scaler_ctrl[prs_pkg::BIT_ABS_RES_SEL];
        output_mode_sel = output_mode_config[prs_pkg::BIT_MODE_SEL];
        count_dir = dir_pin ^ output_mode_config[prs_pkg::BIT_DIR];
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            output_mode_config <= prs_pkg::RST_OUTPUT_MODE;
            scaler_ctrl <= prs_pkg::RST_SCALER_CTRL;
            offset_low_bits <= prs_pkg::RST_OFFSET;
            offset_mid_bits <= prs_pkg::RST_OFFSET;
            interp_and_offset_high <= prs_pkg::RST_OFFSET;
            scale_low_bits <= prs_pkg::RST_SCALE_LOW;
            scale_mid_bits <= prs_pkg::RST_SCALE_MID;
            scale_high_and_control <= prs_pkg::RST_SCALE_HIGH;
        end else if (reg_write) begin
            unique case (reg_addr)
                prs_pkg::ADDR_OUTPUT_MODE: output_mode_config <= reg_wdata;
                prs_pkg::ADDR_SCALER_CTRL: scaler_ctrl <= reg_wdata;
                prs_pkg::ADDR_OFFSET_LOW: offset_low_bits <= reg_wdata;
                prs_pkg::ADDR_OFFSET_MID: offset_mid_bits <= reg_wdata;
                prs_pkg::ADDR_INTERP_HIGH: interp_and_offset_high <= reg_wdata;
                prs_pkg::ADDR_SCALE_LOW: scale_low_bits <= reg_wdata;
                prs_pkg::ADDR_SCALE_MID: scale_mid_bits <= reg_wdata;
                prs_pkg::ADDR_SCALE_HIGH: scale_high_and_control <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (reg_addr)
            prs_pkg::ADDR_OUTPUT_MODE: reg_rdata = output_mode_config;
            prs_pkg::ADDR_SCALER_CTRL: reg_rdata = scaler_ctrl;
            prs_pkg::ADDR_OFFSET_LOW: reg_rdata = offset_low_bits;
            prs_pkg::ADDR_OFFSET_MID: reg_rdata = offset_mid_bits;
            prs_pkg::ADDR_INTERP_HIGH: reg_rdata = interp_and_offset_high;
            prs_pkg::ADDR_SCALE_LOW: reg_rdata = scale_low_bits;
            prs_pkg::ADDR_SCALE_MID: reg_rdata = scale_mid_bits;
            prs_pkg::ADDR_SCALE_HIGH: reg_rdata = scale_high_and_control;
            prs_pkg::ADDR_POS_STATUS:
                reg_rdata = {7'h00, position_valid};
            default: reg_rdata = 8'h00;
        endcase
    end

    // Offset applied at full resolution, then mapped onto the scaled range
    always_comb begin
        rel_pos = abs_position - position_offset;
        if (count_dir) begin
            rel_pos = 18'h00000 - rel_pos;
        end
        res = {1'b0, scale_count_minus_one} + 19'h00001;
        product = PROD_W_L'(rel_pos) * PROD_W_L'(res);
        target = product[35:18];
        if (target >= count) begin
            diff = {1'b0, target - count};
        end else begin
            diff = 19'({1'b0, target} + res - {1'b0, count});
        end
    end

    // Catch-up: one edge per clock, short way round, wrapping at the scale
    always_comb begin
        next_count = count;
        if (diff != 19'h00000) begin
            if (diff <= (res >> 1)) begin
                next_count = (count == scale_count_minus_one) ?
                             18'h00000 : count + 18'h00001;
            end else begin
                next_count = (count == 18'h00000) ?
                             scale_count_minus_one : count - 18'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= scaler_halt;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count <= 18'h00000;
        end else if (scaler_halt || halt_q) begin
            // Restart begins from zero once halt releases
            count <= 18'h00000;
        end else begin
            count <= next_count;
        end
    end

    // Valid follows the interpolator when absolute is at full resolution
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            position_valid <= 1'b0;
        end else if (scaler_halt || halt_q) begin
            position_valid <= 1'b0;
        end else if (absolute_res_sel) begin
            position_valid <= abs_position_ok;
        end else begin
            position_valid <= abs_position_ok &&
                              (diff == 19'h00000);
        end
    end

    prs_gray_map u_gray_map (
        .scale  (scale_count_minus_one),
        .count  (count),
        .excess (excess),
        .gray   (scaled_gray)
    );

    always_comb begin
        full_gray = abs_position ^ (abs_position >> 1);
        if (scaler_disable) begin
            quad_a = abs_position[1];
            quad_b = abs_position[1] ^ abs_position[0];
            index = 1'b0;
        end else begin
            quad_a = count[1];
            quad_b = count[1] ^ count[0];
            index = (count[17:2] == 16'h0000) && count[1];
        end
    end

    // Data outputs registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            quad_a_out <= 1'b0;
            quad_b_out <= 1'b0;
            index_out <= 1'b0;
        end else if (!abz_force_low_n || output_mode_sel) begin
            quad_a_out <= 1'b0;
            quad_b_out <= 1'b0;
            index_out <= 1'b0;
        end else begin
            quad_a_out <= quad_a;
            quad_b_out <= quad_b;
            index_out <= index;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            abs_word_out <= 18'h00000;
            gray_msb_out <= 1'b0;
            gray_msb1_out <= 1'b0;
        end else begin
            if (absolute_res_sel || scaler_disable) begin
                abs_word_out <= full_gray;
            end else begin
                abs_word_out <= scaled_gray;
            end
            gray_msb_out <= full_gray[17];
            gray_msb1_out <= full_gray[16];
        end
    end

    // Power-ok after a settling delay out of reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pwr_cnt <= '0;
            power_ok_out <= 1'b0;
        end else if (pwr_cnt == PWR_DONE) begin
            power_ok_out <= 1'b1;
        end else begin
            pwr_cnt <= pwr_cnt + PWR_W_L'(1);
        end
    end

    always_comb begin
        abz_oe = !abz_tristate && !output_mode_sel;
        parallel_mode = output_mode_sel;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_halt_release;
        $fell(scaler_halt);
    endsequence

    property p_halt_clears_count;
        scaler_halt |=> count == 18'h00000;
    endproperty
    a_halt_clears_count: assert property (p_halt_clears_count)
        else $error("count not held while halted");

    property p_restart_invalid;
        s_halt_release |-> !position_valid ##1 !position_valid;
    endproperty
    a_restart_invalid: assert property (p_restart_invalid)
        else $error("valid set during restart");

    property p_valid_means_caught_up;
        (position_valid && !absolute_res_sel && !$past(absolute_res_sel)
         && !scaler_halt) |-> $past(diff) == 19'h00000;
    endproperty
    a_valid_means_caught_up: assert property (p_valid_means_caught_up)
        else $error("valid without catch-up");

    property p_force_low;
        (!abz_force_low_n) |=> !quad_a_out && !quad_b_out && !index_out;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("quadrature not forced low");

    property p_count_in_range;
        count <= scale_count_minus_one || $changed(scale_count_minus_one)
            || $past(scale_count_minus_one) != scale_count_minus_one;
    endproperty
    a_count_in_range: assert property (p_count_in_range)
        else $error("count beyond scale");

    property p_gray_msbs;
        ##1 gray_msb_out == $past(abs_position[17]) &&
            gray_msb1_out == ($past(abs_position[17]) ^ $past(abs_position[16]));
    endproperty
    a_gray_msbs: assert property (p_gray_msbs)
        else $error("gray msb outputs wrong");

    property p_excess_zero_at_start;
        (count == 18'h00000 && !absolute_res_sel && !scaler_disable)
            |=> abs_word_out == ($past(excess) ^ ($past(excess) >> 1));
    endproperty
    a_excess_zero_at_start: assert property (p_excess_zero_at_start)
        else $error("zero count not mapped to excess");

    property p_single_step;
        (!scaler_halt && !halt_q && !$changed(scale_count_minus_one)
         && count != 18'h00000 && $past(count) != 18'h00000)
            |-> (count - $past(count) <= 18'h00001) ||
                ($past(count) - count <= 18'h00001);
    endproperty
    a_single_step: assert property (p_single_step)
        else $error("count jumped");

    property p_mode_oe;
        output_mode_sel |-> !abz_oe && parallel_mode;
    endproperty
    a_mode_oe: assert property (p_mode_oe)
        else $error("parallel mode leaves outputs enabled");
endmodule : prs_scaler
`default_nettype wire

// *** tb/prs_quad_counter.sv ***
// Partner model: incremental counter fed by the quadrature pair
`timescale 1ns/1ns
`default_nettype none
module prs_quad_counter (
    input  wire logic               clk,
    input  wire logic               clr,
    input  wire logic               quad_a,
    input  wire logic               quad_b,
    output logic signed [19:0]      count,
    output logic                    step_err
);
    logic [1:0] phase;
    logic [1:0] last_phase;
    logic [1:0] delta;

    // A and A^B form a binary phase, so one step is plus or minus one
    assign phase = {quad_a, quad_a ^ quad_b};
    assign delta = phase - last_phase;

    always_ff @(posedge clk) begin
        if (clr) begin
            count <= '0;
            step_err <= 1'b0;
        end else if (delta == 2'd1) begin
            count <= count + 20'sd1;
        end else if (delta == 2'd3) begin
            count <= count - 20'sd1;
        end else if (delta == 2'd2) begin
            // A skipped phase cannot be told apart in direction
            step_err <= 1'b1;
        end
        last_phase <= phase;
    end
endmodule : prs_quad_counter
`default_nettype wire

// *** tb/prs_scaler_tb.sv ***
// Testbench: register-level tests of the resolution scaler
`timescale 1ns/1ns
`default_nettype none
module prs_scaler_tb;
    logic               clk;
    logic               reset_n;
    logic        [7:0]  reg_addr;
    logic        [7:0]  reg_wdata;
    logic               reg_write;
    logic        [7:0]  reg_rdata;
    logic        [17:0] abs_position;
    logic               abs_position_ok;
    logic               dir_pin;
    logic               quad_a_out, quad_b_out, index_out, abz_oe;
    logic               gray_msb_out, gray_msb1_out, power_ok_out;
    logic               parallel_mode, position_valid;
    logic        [17:0] abs_word_out;
    logic               clr;
    logic signed [19:0] qcount;
    logic               qerr;
    int                 miscompares;
    int                 total_checks;
    int                 n;
    logic        [7:0]  ra [10] = '{8'h07, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                                   8'h0f, 8'h10, 8'h11, 8'h00, 8'h13};
    logic        [7:0]  re [10] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
                                   8'h7f, 8'h7f, 8'h0f, 8'h00, 8'h00};

    prs_scaler i_prs_scaler (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
        .abs_position(abs_position), .abs_position_ok(abs_position_ok),
        .dir_pin(dir_pin), .quad_a_out(quad_a_out), .quad_b_out(quad_b_out),
        .index_out(index_out), .abz_oe(abz_oe), .gray_msb_out(gray_msb_out),
        .gray_msb1_out(gray_msb1_out), .power_ok_out(power_ok_out),
        .parallel_mode(parallel_mode), .abs_word_out(abs_word_out),
        .position_valid(position_valid)
    );

    prs_quad_counter i_prs_quad_counter (
        .clk(clk), .clr(clr), .quad_a(quad_a_out), .quad_b(quad_b_out),
        .count(qcount), .step_err(qerr)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [17:0] gray(input logic [17:0] x);
        return x ^ (x >> 1);
    endfunction : gray

    function automatic logic [17:0] exc(input logic [17:0] s);
        int b = 0;
        while ((s >> b) != 18'h0) b++;
        return 18'(((1 << b) - (int'(s) + 1)) / 2);
    endfunction : exc

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk_bit(input logic g, input logic e, input string m);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [17:0] g, input logic [17:0] e,
                           input string m);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk_val

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick(1);
        reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string m);
        tick(1);
        reg_addr = a;
        #1;
        chk_val(18'(reg_rdata), 18'(e), m);
    endtask : rd

    // Bounded wait; a stuck scaler ends the run as a failure
    task automatic wait_valid();
        int k = 0;
        while (position_valid !== 1'b1 && k < 600) begin
            tick(1);
            k++;
        end
        if (k >= 600) begin
            miscompares++;
            $display("[ERR] %0t position never valid", $time);
            results();
        end
    endtask : wait_valid

    task automatic run(input logic [17:0] s, input logic [17:0] o,
                       input logic dr, input logic dp,
                       input logic [17:0] p, input logic [17:0] cnt,
                       input logic [17:0] w, input string nm);
        wr(8'h11, {4'b0010, s[17:14]});
        clr = 1'b1;
        wr(8'h0f, {1'b0, s[6:0]});
        wr(8'h10, {1'b0, s[13:7]});
        wr(8'h0c, {1'b0, o[6:0]});
        wr(8'h0d, {1'b0, o[13:7]});
        wr(8'h0e, {4'h0, o[17:14]});
        wr(8'h07, {2'b00, dr, 5'h00});
        dir_pin = dp;
        abs_position = p;
        chk_bit(position_valid, 1'b0, "valid while halted");
        rd(8'h12, 8'h00, "status while halted");
        chk_val(abs_word_out, gray(exc(s)), "zero word");
        clr = 1'b0;
        wr(8'h11, {4'b0100, s[17:14]});
        wait_valid();
        tick(2);
        chk_val(abs_word_out, w, "scaled word");
        chk_val(18'(qcount), cnt, "quadrature steps");
        chk_bit(qerr, 1'b0, "quadrature skip");
        rd(8'h12, 8'h01, "status valid");
        $display("test %s done", nm);
    endtask : run

    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        abs_position = 18'h0;
        abs_position_ok = 1'b1;
        dir_pin = 1'b0;
        clr = 1'b1;
        miscompares = 0;
        total_checks = 0;
        n = 0;
        tick(6);
        reset_n = 1'b1;
        while (power_ok_out !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk_bit(n >= 199 && n <= 202, 1'b1, "power ok delay");
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], re[i], "reset value");
        end
        wr(8'h0c, 8'h2a);
        rd(8'h0c, 8'h2a, "offset readback");
        $display("test registers done");
        wr(8'h07, 8'h10);
        chk_bit(parallel_mode, 1'b1, "parallel mode");
        wr(8'h0b, 8'h00);
        chk_bit(abz_oe, 1'b0, "pins in parallel mode");
        wr(8'h07, 8'h00);
        chk_bit(parallel_mode, 1'b0, "interface mode");
        chk_bit(abz_oe, 1'b1, "pins driven");
        $display("test mode done");
        run(18'h00063, 18'h0, 1'b0, 1'b0, 18'h20000, 18'd50, 18'h00060,
            "scaled");
        chk_bit(quad_a_out, 1'b1, "quad a");
        chk_bit(quad_b_out, 1'b1, "quad b");
        chk_bit(index_out, 1'b0, "index off");
        chk_bit(gray_msb_out, 1'b1, "gray msb");
        chk_bit(gray_msb1_out, 1'b1, "gray msb1");
        wr(8'h11, 8'h00);
        tick(2);
        chk_bit(quad_a_out, 1'b0, "forced a");
        chk_bit(quad_b_out, 1'b0, "forced b");
        run(18'h00063, 18'h0, 1'b0, 1'b0, 18'h01500, 18'd2, 18'h00018,
            "index");
        chk_bit(index_out, 1'b1, "index on");
        wr(8'h0b, 8'h02);
        tick(2);
        chk_bit(index_out, 1'b0, "bypass index");
        chk_bit(gray_msb_out, 1'b0, "bypass gray msb");
        wr(8'h0b, 8'h00);
        // Target 80 of 128: short way is 48 steps down through the wrap
        run(18'h0007f, 18'h10000, 1'b1, 1'b1, 18'h38000, 18'h3ffd0, 18'h00078,
            "binary forward");
        chk_bit(gray_msb1_out, 1'b0, "gray msb1 low");
        run(18'h0007f, 18'h10000, 1'b0, 1'b1, 18'h38000, 18'd48, 18'h00028,
            "binary reversed");
        wr(8'h0b, 8'h04);
        abs_position_ok = 1'b0;
        tick(2);
        chk_bit(position_valid, 1'b0, "full res invalid");
        chk_val(abs_word_out, gray(18'h38000), "full res word");
        abs_position_ok = 1'b1;
        wait_valid();
        chk_bit(position_valid, 1'b1, "full res valid");
        $display("test absolute select done");
        results();
    end
endmodule : prs_scaler_tb
`default_nettype wire
